// ===== design/ccirs_defines.vh
// Register map, field positions, reset values and timing figures
`ifndef CCIRS_DEFINES_VH
`define CCIRS_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CCIRS_ADR_CTRL       8'h00
`define CCIRS_ADR_TIMER      8'h04
`define CCIRS_ADR_CH_EN      8'h08
`define CCIRS_ADR_SYNC_EN    8'h0c
`define CCIRS_ADR_PULSE_MODE 8'h10
`define CCIRS_ADR_STATUS     8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CCIRS_CTRL_RESTART   0
`define CCIRS_CTRL_RESEED    1
`define CCIRS_CTRL_PULSE     2
`define CCIRS_CTRL_CNT_LO    4
`define CCIRS_CTRL_CNT_HI    7

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define CCIRS_STAT_PLLB_LOCK 0
`define CCIRS_STAT_PLLA_LOCK 1
`define CCIRS_STAT_PHASED    2
`define CCIRS_STAT_ALIGNING  3
`define CCIRS_STAT_PULSING   4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCIRS_RST_TIMER      12'h010
`define CCIRS_RST_PULSE_CNT  4'h4

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define CCIRS_CLK_MHZ        10
`define CCIRS_PLLB_LOCK_US   50
`define CCIRS_PLLA_LOCK_MS   50
`define CCIRS_ALIGN_PERIODS  6

`endif

// ===== design/ccirs_sequencer.v
// Clock chip restart, lock, reseed and pulse generator sequencer
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "ccirs_defines.vh"

module ccirs_sequencer
#(
  parameter N_CH        = 14,
  parameter PLLB_CYCLES = `CCIRS_PLLB_LOCK_US * `CCIRS_CLK_MHZ,
  parameter PLLA_CYCLES = `CCIRS_PLLA_LOCK_MS * 1000 * `CCIRS_CLK_MHZ
)
(
  input  wire            clk,
  input  wire            reset_n,
  input  wire            wb_cyc_i,
  input  wire            wb_stb_i,
  input  wire            wb_we_i,
  input  wire [7:0]      wb_adr_i,
  input  wire [3:0]      wb_sel_i,
  input  wire [31:0]     wb_dat_i,
  output reg  [31:0]     wb_dat_o,
  output reg             wb_ack_o,
  input  wire            ref_clk_in,
  output reg  [N_CH-1:0] sysref_out,
  output reg  [N_CH-1:0] ch_sync_strobe,
  output wire            pll_b_locked,
  output wire            pll_a_locked,
  output wire            outputs_phased
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'd0;
  localparam ST_ALIGN = 2'd1;
  localparam ST_PULSE = 2'd2;
  localparam ST_ARM   = 2'd3;
  localparam PAD      = 32 - N_CH;

  reg  [1:0]      state_r;
  reg             restart_r;
  reg  [3:0]      pulse_cnt_cfg_r;
  reg  [11:0]     period_r;
  reg  [N_CH-1:0] ch_en_r;
  reg  [N_CH-1:0] sync_en_r;
  reg  [N_CH-1:0] pulse_mode_r;
  reg  [N_CH-1:0] hold_r;
  reg  [31:0]     pllb_cnt_r;
  reg  [31:0]     plla_cnt_r;
  reg             pllb_lock_r;
  reg             plla_lock_r;
  reg             phased_r;
  reg  [2:0]      align_cnt_r;
  reg  [3:0]      pulses_left_r;
  reg  [11:0]     tmr_cnt_r;
  reg             ref_meta_r;
  reg             ref_sync_r;
  reg             ref_prev_r;
  wire [N_CH-1:0] run_mask;
  reg  [31:0]     rd_data;
  wire            wr_go;
  wire            rd_go;
  wire            ref_rise;
  wire [11:0]     period_eff;
  wire            tick;
  wire            phase_hi;
  wire            reseed_go;
  wire            pulse_go;
  wire [31:0]     tmr_mrg;
  wire [31:0]     chn_mrg;
  wire [31:0]     syn_mrg;
  wire [31:0]     pmd_mrg;

  // Byte lane merge for a register write
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer      k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_go = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // Requests act on a write to the control low byte
  assign reseed_go = wr_go & wb_sel_i[0] & (wb_adr_i == `CCIRS_ADR_CTRL)
                     & wb_dat_i[`CCIRS_CTRL_RESEED];
  assign pulse_go  = wr_go & wb_sel_i[0] & (wb_adr_i == `CCIRS_ADR_CTRL)
                     & wb_dat_i[`CCIRS_CTRL_PULSE];
  // Register images with the written byte lanes merged in
  assign tmr_mrg = lane_merge({20'h000, period_r}, wb_dat_i, wb_sel_i);
  assign chn_mrg = lane_merge({{PAD{1'b0}}, ch_en_r}, wb_dat_i, wb_sel_i);
  assign syn_mrg = lane_merge({{PAD{1'b0}}, sync_en_r}, wb_dat_i, wb_sel_i);
  assign pmd_mrg = lane_merge({{PAD{1'b0}}, pulse_mode_r}, wb_dat_i, wb_sel_i);

  // Read mux; unmapped addresses read zero
  always @*
  begin
    rd_data = 32'h0;
    case (wb_adr_i)
      `CCIRS_ADR_CTRL:
      begin
        rd_data[`CCIRS_CTRL_RESTART] = restart_r;
        rd_data[`CCIRS_CTRL_CNT_HI:`CCIRS_CTRL_CNT_LO] = pulse_cnt_cfg_r;
      end
      `CCIRS_ADR_TIMER:      rd_data[11:0] = period_r;
      `CCIRS_ADR_CH_EN:      rd_data[N_CH-1:0] = ch_en_r;
      `CCIRS_ADR_SYNC_EN:    rd_data[N_CH-1:0] = sync_en_r;
      `CCIRS_ADR_PULSE_MODE: rd_data[N_CH-1:0] = pulse_mode_r;
      `CCIRS_ADR_STATUS:
      begin
        rd_data[`CCIRS_STAT_PLLB_LOCK] = pllb_lock_r;
        rd_data[`CCIRS_STAT_PLLA_LOCK] = plla_lock_r;
        rd_data[`CCIRS_STAT_PHASED]    = phased_r;
        rd_data[`CCIRS_STAT_ALIGNING]  = (state_r == ST_ALIGN);
        rd_data[`CCIRS_STAT_PULSING]   = (state_r == ST_PULSE);
      end
      default: rd_data = 32'h0;
    endcase
  end

  // Ack one cycle after the request, data and writes on the same edge
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h0;
      restart_r       <= 1'b0;
      pulse_cnt_cfg_r <= `CCIRS_RST_PULSE_CNT;
      period_r        <= `CCIRS_RST_TIMER;
      ch_en_r         <= {N_CH{1'b0}};
      sync_en_r       <= {N_CH{1'b1}};
      pulse_mode_r    <= {N_CH{1'b0}};
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_go)
        wb_dat_o <= rd_data;
      if (wr_go)
      begin
        case (wb_adr_i)
          `CCIRS_ADR_CTRL:
            if (wb_sel_i[0])
            begin
              restart_r       <= wb_dat_i[`CCIRS_CTRL_RESTART];
              pulse_cnt_cfg_r <=
                wb_dat_i[`CCIRS_CTRL_CNT_HI:`CCIRS_CTRL_CNT_LO];
            end
          `CCIRS_ADR_TIMER:      period_r     <= tmr_mrg[11:0];
          `CCIRS_ADR_CH_EN:      ch_en_r      <= chn_mrg[N_CH-1:0];
          `CCIRS_ADR_SYNC_EN:    sync_en_r    <= syn_mrg[N_CH-1:0];
          `CCIRS_ADR_PULSE_MODE: pulse_mode_r <= pmd_mrg[N_CH-1:0];
          default: restart_r <= restart_r;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference clock sampling and pulse period timer
  // ----------------------------------------------------------------
  assign ref_rise   = ref_sync_r & ~ref_prev_r;
  assign period_eff = (period_r == 12'h000) ? 12'h001 : period_r;
  assign tick       = ref_rise & (tmr_cnt_r == period_eff - 12'h001);
  assign phase_hi   = (tmr_cnt_r < {1'b0, period_eff[11:1]});

  // Timer counts reference edges; cleared while restart is set
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_meta_r <= 1'b0;
      ref_sync_r <= 1'b0;
      ref_prev_r <= 1'b0;
      tmr_cnt_r  <= 12'h000;
    end
    else
    begin
      ref_meta_r <= ref_clk_in;
      ref_sync_r <= ref_meta_r;
      ref_prev_r <= ref_sync_r;
      if (restart_r || tick)
        tmr_cnt_r <= 12'h000;
      else if (ref_rise)
        tmr_cnt_r <= tmr_cnt_r + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // PLL lock timers, both started by the restart release
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pllb_cnt_r  <= 32'h0;
      plla_cnt_r  <= 32'h0;
      pllb_lock_r <= 1'b0;
      plla_lock_r <= 1'b0;
    end
    else if (restart_r)
    begin
      pllb_cnt_r  <= 32'h0;
      plla_cnt_r  <= 32'h0;
      pllb_lock_r <= 1'b0;
      plla_lock_r <= 1'b0;
    end
    else
    begin
      if (!pllb_lock_r)
        pllb_cnt_r <= pllb_cnt_r + 32'h1;
      if (!plla_lock_r)
        plla_cnt_r <= plla_cnt_r + 32'h1;
      if (pllb_cnt_r >= PLLB_CYCLES - 1)
        pllb_lock_r <= 1'b1;
      if (plla_cnt_r >= PLLA_CYCLES - 1)
        plla_lock_r <= 1'b1;
    end
  end

  assign pll_b_locked   = pllb_lock_r;
  assign pll_a_locked   = plla_lock_r;
  assign outputs_phased = phased_r;

  // ----------------------------------------------------------------
  // Reseed and pulse generator state machine
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r        <= ST_IDLE;
      phased_r       <= 1'b0;
      align_cnt_r    <= 3'd0;
      pulses_left_r  <= 4'h0;
      hold_r         <= {N_CH{1'b0}};
      ch_sync_strobe <= {N_CH{1'b0}};
    end
    else
    begin
      ch_sync_strobe <= {N_CH{1'b0}};
      if (restart_r)
      begin
        state_r  <= ST_IDLE;
        phased_r <= 1'b0;
        hold_r   <= {N_CH{1'b0}};
      end
      else
      begin
        case (state_r)
          ST_IDLE:
            // Reseed only honoured once the second PLL is locked
            if (reseed_go && pllb_lock_r)
            begin
              state_r        <= ST_ALIGN;
              phased_r       <= 1'b0;
              align_cnt_r    <= 3'd0;
              hold_r         <= sync_en_r;
              ch_sync_strobe <= sync_en_r;
            end
            else if (pulse_go)
              state_r <= ST_ARM;
          ST_ALIGN:
            if (tick)
            begin
              if (align_cnt_r == `CCIRS_ALIGN_PERIODS - 1)
              begin
                phased_r      <= 1'b1;
                hold_r        <= {N_CH{1'b0}};
                state_r       <= ST_PULSE;
                pulses_left_r <= pulse_cnt_cfg_r;
              end
              else
                align_cnt_r <= align_cnt_r + 3'd1;
            end
          ST_ARM:
            if (tick)                              // Start on a period edge
            begin
              state_r       <= ST_PULSE;
              pulses_left_r <= pulse_cnt_cfg_r;
            end
          ST_PULSE:
            if (pulses_left_r == 4'h0)
              state_r <= ST_IDLE;
            else if (tick)
              pulses_left_r <= pulses_left_r - 4'h1;
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference pulse outputs
  // ----------------------------------------------------------------
  // Pulse mode channels run only during a burst; held channels stay low
  assign run_mask = ch_en_r & ~hold_r & ~(pulse_mode_r &
                    {N_CH{(state_r != ST_PULSE) || (pulses_left_r == 4'h0)}});

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sysref_out <= {N_CH{1'b0}};
    else
      sysref_out <= run_mask & {N_CH{phase_hi & ~restart_r}};
  end

endmodule

// ===== verification/ccirs_seq_sva.sv
// Bus, lock and reseed assertions for the sequencer
`timescale 1ns/1ps
module ccirs_seq_sva
#(
  parameter N_CH        = 14,
  parameter PLLB_CYCLES = 500,
  parameter PLLA_CYCLES = 500000
)
(
  input wire            clk,
  input wire            reset_n,
  input wire            wb_cyc_i,
  input wire            wb_stb_i,
  input wire            wb_we_i,
  input wire [7:0]      wb_adr_i,
  input wire [3:0]      wb_sel_i,
  input wire [31:0]     wb_dat_i,
  input wire [31:0]     wb_dat_o,
  input wire            wb_ack_o,
  input wire            ref_clk_in,
  input wire [N_CH-1:0] sysref_out,
  input wire [N_CH-1:0] ch_sync_strobe,
  input wire            pll_b_locked,
  input wire            pll_a_locked,
  input wire            outputs_phased
);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  wire stb_any = |ch_sync_strobe;

  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_REQ: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  AST_RD_UNMAP: assert property (rd_req && wb_adr_i > 8'h14 |=>
    wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_STAT_RD: assert property (rd_req && wb_adr_i == 8'h14 |=>
    wb_dat_o[0] == $past(pll_b_locked) && wb_dat_o[2] == $past(outputs_phased))
    else $error("status read mismatch");
  AST_STROBE_ONE: assert property (stb_any |=> !stb_any)
    else $error("sync strobe too long");
  AST_STROBE_LOCK: assert property (stb_any |-> pll_b_locked)
    else $error("sync strobe without lock");
  AST_STROBE_CAUSE: assert property (stb_any |->
    $past(wb_we_i && wb_dat_i[1]) || $past(wb_we_i && wb_dat_i[1], 2))
    else $error("sync strobe without reseed write");
  AST_PHASED_DROP: assert property (stb_any |=> !outputs_phased [*3])
    else $error("phased too early");
  AST_PHASED_LOCK: assert property (outputs_phased |-> pll_b_locked)
    else $error("phased without lock");
  AST_A_AFTER_B: assert property (pll_a_locked |-> pll_b_locked)
    else $error("first loop locked before second");
  AST_HOLD_LOW: assert property (stb_any |=>
    (sysref_out & $past(ch_sync_strobe)) == {N_CH{1'b0}})
    else $error("synced channel not held low");
  cover property ($rose(pll_b_locked));
  cover property ($rose(outputs_phased));
  cover property ($rose(pll_a_locked));
endmodule

bind ccirs_sequencer ccirs_seq_sva #(.N_CH(N_CH), .PLLB_CYCLES(PLLB_CYCLES),
  .PLLA_CYCLES(PLLA_CYCLES)) sva_u (.clk(clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_clk_in(ref_clk_in),
  .sysref_out(sysref_out), .ch_sync_strobe(ch_sync_strobe),
  .pll_b_locked(pll_b_locked), .pll_a_locked(pll_a_locked),
  .outputs_phased(outputs_phased));

// ===== verification/ccirs_ref_src.sv
// Free-running reference clock source on the far side
`timescale 1ns/1ps
module ccirs_ref_src
#(
  parameter HALF_NS = 400
)
(
  output reg ref_clk
);
  // Present from time zero, offset in phase from the system clock
  initial
  begin
    ref_clk = 1'b0;
    #137;
    forever #(HALF_NS) ref_clk = ~ref_clk;
  end
endmodule

// ===== verification/tb.sv
// Self-checking bench for the sequencer
`timescale 1ns/1ps
module tb;
  localparam NC = 14;
  localparam PB = 50;
  localparam PA = 2000;
  reg           clk;
  reg           reset_n;
  reg           cyc;
  reg           stb;
  reg           we;
  reg  [7:0]    adr;
  reg  [3:0]    sel;
  reg  [31:0]   dat;
  wire [31:0]   dat_o;
  wire          ack;
  wire          ref_clk;
  wire [NC-1:0] sysref;
  wire [NC-1:0] strobe;
  wire          lock_b;
  wire          lock_a;
  wire          phased;
  integer       fail_count;
  integer       n_tests;
  integer       rise0;
  integer       rise1;
  integer       c;
  integer       n;
  reg  [NC-1:0] prev;
  reg  [31:0]   q;
  reg  [31:0]   mdl [0:4];
  reg  [NC-1:0] stq [$];

  ccirs_ref_src ref_u (.ref_clk(ref_clk));
  ccirs_sequencer #(.N_CH(NC), .PLLB_CYCLES(PB), .PLLA_CYCLES(PA)) dut_u (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ref_clk_in(ref_clk),
    .sysref_out(sysref), .ch_sync_strobe(strobe), .pll_b_locked(lock_b),
    .pll_a_locked(lock_a), .outputs_phased(phased));

  // System clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Rising edges on two channels and captured sync strobes
  always @(posedge clk)
  begin
    prev <= sysref;
    if (sysref[0] && !prev[0]) rise0 = rise0 + 1;
    if (sysref[1] && !prev[1]) rise1 = rise1 + 1;
    if (|strobe) stq.push_back(strobe);
  end

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count = fail_count + 1;
    end
  end
  endtask

  task results;
  begin
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  task tmo;
  begin
    fail_count = fail_count + 1;
    results;
  end
  endtask

  // One classic cycle; read data lands in q
  task wb(input w, input [7:0] a, input [31:0] d);
    integer i;
  begin
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    i = 0;
    do
    begin
      @(posedge clk);
      i = i + 1;
    end
    while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) tmo;
    else
    begin
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  end
  endtask

  // Write and update the register model with the writable bits
  task wr(input [7:0] a, input [31:0] d);
  begin
    wb(1'b1, a, d);
    case (a)
      8'h00: mdl[0] = d & 32'hf1;
      8'h04: mdl[1] = d & 32'hfff;
      8'h08, 8'h0c, 8'h10: mdl[a[4:2]] = d & 32'h3fff;
      default: ;
    endcase
  end
  endtask

  // Bounded wait for lock b (0), phased (1) or lock a (2)
  task wt(input integer s, input integer lim);
  begin
    c = 0;
    while ((s == 0 ? lock_b : s == 1 ? phased : lock_a) !== 1'b1 && c < lim)
    begin
      @(posedge clk);
      c = c + 1;
    end
    if (c >= lim) tmo;
  end
  endtask

  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial
  begin
    fail_count = 0;
    n_tests = 0;
    rise0 = 0;
    rise1 = 0;
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    prev = '0;
    mdl[0] = 32'h40;
    mdl[1] = 32'h010;
    mdl[2] = 32'h0;
    mdl[3] = 32'h3fff;
    mdl[4] = 32'h0;
    n = $urandom(3);
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (n = 0; n < 5; n = n + 1)
    begin
      wb(1'b0, 8'(4 * n), 32'h0);
      chk(q, mdl[n]);
    end
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    n = $urandom;
    wr(8'h04, n);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, mdl[1]);
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h3);
    wr(8'h0c, 32'h1);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h41);
    wr(8'h00, 32'h43);
    repeat (4) @(posedge clk);
    chk(stq.size(), 0);
    wr(8'h00, 32'h40);
    wt(0, 200);
    chk(c >= PB - 2 && c <= PB + 3, 1);
    chk(lock_a, 0);
    wb(1'b0, 8'h14, 32'h0);
    chk(q[0], 1);
    rise0 = 0;
    rise1 = 0;
    wr(8'h00, 32'h42);
    wt(1, 400);
    chk(c > 150 && c < 230, 1);
    chk(stq.pop_front(), 32'h1);
    chk(rise0, 0);
    chk(rise1 > 2, 1);
    rise0 = 0;
    repeat (256) @(posedge clk);
    chk(rise0, 4);
    repeat (384) @(posedge clk);
    n = 1 + $urandom % 4;
    rise0 = 0;
    wr(8'h00, (n << 4) | 4);
    repeat ((n + 3) * 32) @(posedge clk);
    chk(rise0, n);
    wr(8'h08, 32'h1);
    repeat (4) @(posedge clk);
    rise1 = 0;
    repeat (64) @(posedge clk);
    chk(rise1, 0);
    wt(2, 3000);
    wb(1'b0, 8'h14, 32'h0);
    chk(q[2:0], 3'h7);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, mdl[0]);
    results;
  end
endmodule
